// ### dv/apst_selftest_chk.sv
`timescale 1ns/1ps
`default_nettype none
module apst_selftest_chk #(
  parameter int SLOT_CYCLES = 20
) (
  // clock and control
  input wire logic                       ref_clk_in,
  input wire logic                       reset_in,
  input wire logic                       ce_in,
  // bus
  input wire logic                       wb_cyc_in,
  input wire logic                       wb_stb_in,
  input wire logic                       wb_we_in,
  input wire logic [7:0]                 wb_adr_in,
  input wire logic [3:0]                 wb_sel_in,
  input wire logic [31:0]                wb_dat_in,
  input wire logic                       wb_ack_out,
  // tests and results
  input wire logic [apst_pkg::N_SEL-1:0] test_start_out,
  input wire logic [apst_pkg::N_SEL-1:0] test_ready_in,
  input wire apst_pkg::apst_fixed_data_t fixed_data_in,
  input wire logic                       seventeen_point_calibration_in,
  input wire logic                       div_to_angle_out,
  input wire logic                       diag_request_out
);
  import apst_pkg::*;
  localparam int LAT = 16 * SLOT_CYCLES + 8;
  logic [12:0] set_m, next_set_m;
  logic [15:0] run_cnt, next_run_cnt;
  logic [4:0]  prev_start, en_now, done_now;
  assign en_now = {5{set_m[0]}} & set_m[5:1];
  assign done_now = test_start_out & test_ready_in;
  // settings mirror and length of one start
  always_comb begin
    next_set_m = set_m;
    if (wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out && wb_adr_in == REG_SETTINGS) begin
      if (wb_sel_in[0]) next_set_m[7:0] = wb_dat_in[7:0];
      if (wb_sel_in[1]) next_set_m[12:8] = wb_dat_in[12:8];
    end
    next_run_cnt = (test_start_out != 5'h00 && test_start_out == prev_start) ? run_cnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      set_m <= {RST_MASKS, RST_TESTS, RST_GLOBAL};
      run_cnt <= 16'h0000;
      prev_start <= 5'h00;
    end else if (ce_in) begin
      set_m <= next_set_m;
      run_cnt <= next_run_cnt;
      prev_start <= test_start_out;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  chk_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in |=> wb_ack_out)
    else $error("bus request not answered");
  chk_ack_single: assert property (wb_ack_out && ce_in |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  chk_diag_sticky: assert property (diag_request_out |=> diag_request_out)
    else $error("diagnostic request dropped");
  chk_start_gated: assert property ((test_start_out & ~prev_start & ~(en_now | $past(en_now) | $past(en_now, 2))) == 5'h00)
    else $error("disabled test started");
  chk_ready_clears: assert property (ce_in && done_now != 5'h00 |=> (test_start_out & $past(done_now)) == 5'h00)
    else $error("start held after ready");
  chk_start_bound: assert property (run_cnt < SLOT_CYCLES + 2)
    else $error("start outlived its slot");
  chk_div_copy: assert property (!$past(reset_in) && $past(ce_in) |-> div_to_angle_out == $past(seventeen_point_calibration_in))
    else $error("division routing wrong");
  chk_ctrl_diag: assert property (ce_in && fixed_data_in.ctrl_error && !set_m[6] |-> ##[1:3] diag_request_out)
    else $error("control error without diagnostic");
  chk_clamp_diag: assert property (ce_in && fixed_data_in.clamp_det && !fixed_data_in.range_det && !set_m[12]
    |-> ##[1:3] diag_request_out)
    else $error("clamp order fault without diagnostic");
  chk_noready_diag: assert property (!$past(reset_in) && ($past(test_start_out) & ~test_start_out & ~$past(test_ready_in)
    & en_now & $past(en_now)) != 5'h00 |-> ##[0:LAT] diag_request_out)
    else $error("missing ready not reported");
  // main scenarios
  cover property ($rose(diag_request_out));
  cover property (done_now != 5'h00);
  cover property (wb_ack_out && !wb_we_in && wb_adr_in == REG_FLAGS);
endmodule
bind apst_selftest apst_selftest_chk #(.SLOT_CYCLES(SLOT_CYCLES)) u_chk (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in), .ce_in(ce_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out),
  .test_start_out(test_start_out), .test_ready_in(test_ready_in), .fixed_data_in(fixed_data_in),
  .seventeen_point_calibration_in(seventeen_point_calibration_in), .div_to_angle_out(div_to_angle_out),
  .diag_request_out(diag_request_out));
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import apst_pkg::*;
  localparam int SLOT = 20;
  localparam int FW   = 2 * SEQ_SLOTS * SLOT + 20;
  logic             ref_clk_in = 1'b0;
  logic             reset_in = 1'b1;
  logic             cyc = 1'b0, stb = 1'b0, we = 1'b0, resp = 1'b1, spc = 1'b0, ack;
  logic             ce = 1'b1, spc_d = 1'b0, rst_d = 1'b1, ce_d = 1'b1, div, diag;
  logic [7:0]       adr = 8'h00;
  logic [31:0]      wdat = 32'h0, rdat;
  logic [4:0]       start, ready = 5'h00;
  apst_test_data_t  td, good;
  apst_fixed_data_t fd, idle;
  logic [63:0]      q[$];
  int               error_cnt = 0, compares = 0;
  always #2.5 ref_clk_in = ~ref_clk_in;
  apst_selftest #(.SLOT_CYCLES(SLOT)) u_dut (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .ce_in(ce), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .test_start_out(start), .test_ready_in(ready), .test_data_in(td), .fixed_data_in(fd),
    .seventeen_point_calibration_in(spc), .div_to_angle_out(div), .diag_request_out(diag));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one classic cycle; a read notes its masked expectation
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge ref_clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    if (!w) q.push_back({m, d});
    do @(posedge ref_clk_in); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic waitf();
    repeat (FW) @(posedge ref_clk_in);
  endtask
  // read data against the oldest note
  always @(posedge ref_clk_in) begin
    if (ack === 1'b1 && !we) begin
      check(rdat & q[0][63:32], q[0][31:0]);
      if (adr == REG_STATUS) check({31'h0, diag}, {31'h0, q[0][0]});
      void'(q.pop_front());
    end
  end
  // test engines answer one cycle after start; random mode level
  always @(posedge ref_clk_in) begin
    ready <= start & ~ready & {5{resp}};
    spc <= ^$urandom();
    spc_d <= spc;
    rst_d <= reset_in;
    ce_d <= ce;
    if (!rst_d && ce_d) check({31'h0, div}, {31'h0, spc_d});
  end
  function automatic apst_fixed_data_t fault(int i);
    fault = idle;
    case (i)
      F_CTRL: fault.ctrl_error = 1'b1;
      F_CONV: fault.sd_result = 16'h799A;
      F_ADD: fault.adder_ovf = 1'b1;
      F_ROTOV: fault.rotation_ovf = 1'b1;
      default: fault.clamp_det = 1'b1;
    endcase
  endfunction
  function automatic apst_test_data_t bad(int t);
    bad = good;
    case (t)
      T_FIELD: bad.temp_amr = good.temp_chip + 12'h0C8;
      T_INV: bad.inv_angle = good.inv_angle + 16'h0001;
      T_DIV: bad.div_result = 16'h1235;
      T_ROT: bad.cordic_inv = good.cordic_inv + 16'h0001;
      default: bad.zero_red = good.zero_red + 16'h0001;
    endcase
  endfunction
  // main sequence
  initial begin
    void'($urandom(32'h9D49AAAB));
    good = '0;
    good.temp_chip = 12'h100;
    good.temp_amr = 12'h100;
    good.div_result = 16'h1234;
    good.clamp_lo = 16'($urandom_range(0, 16'h3FFF));
    good.clamp_hi = 16'($urandom_range(0, 16'h3FFF));
    good.main_angle = 16'($urandom_range(0, good.clamp_lo + good.clamp_hi));
    good.inv_angle = good.clamp_lo + good.clamp_hi - good.main_angle;
    good.cordic_main = 16'($urandom());
    good.cordic_inv = -good.cordic_main;
    good.zero_main = 16'($urandom());
    good.zero_red = good.zero_main;
    idle = '0;
    idle.sd_gain = 8'h80;
    idle.sd_result = 16'h7999;
    td = good;
    fd = idle;
    repeat (4) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    bus(1'b0, REG_SETTINGS, 32'h0000003F, 32'h00001FFF);
    bus(1'b0, 8'h10, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, REG_SETTINGS, 32'h00001FFF, 32'h0);
    waitf();
    bus(1'b0, REG_FLAGS, 32'h0, 32'h00000FFF);
    bus(1'b1, REG_SETTINGS, 32'h00001FEF, 32'h0);
    td <= bad(T_ROT);
    waitf();
    bus(1'b0, REG_FLAGS, 32'h0, 32'h0000001F);
    bus(1'b1, REG_SETTINGS, 32'h00001FFE, 32'h0);
    td <= bad(T_DIV);
    waitf();
    bus(1'b0, REG_FLAGS, 32'h0, 32'h0000001F);
    bus(1'b1, REG_SETTINGS, 32'h00001FFF, 32'h0);
    td <= good;
    for (int i = 0; i < N_FIX; i++) begin
      if (i == F_COMPL || i == F_PAR) continue;
      fd <= fault(i);
      repeat (3) @(posedge ref_clk_in);
      fd <= idle;
      bus(1'b0, REG_FLAGS, 32'h1 << (FLG_FIX_POS + i), 32'h1 << (FLG_FIX_POS + i));
      bus(1'b1, REG_FLAGS, 32'h1 << (FLG_FIX_POS + i), 32'h0);
    end
    bus(1'b0, REG_FLAGS, 32'h0, 32'h00000FFF);
    bus(1'b0, REG_STATUS, 32'h0, 32'h1);
    for (int t = 0; t < N_SEL; t++) begin
      td <= bad(t);
      waitf();
      bus(1'b0, REG_FLAGS, 32'h1 << t, 32'h1 << t);
    end
    bus(1'b0, REG_STATUS, 32'h1, 32'h1);
    td <= good;
    waitf();
    bus(1'b1, REG_FLAGS, 32'h00000FFF, 32'h0);
    bus(1'b0, REG_FLAGS, 32'h0, 32'h00000FFF);
    resp <= 1'b0;
    waitf();
    bus(1'b0, REG_FLAGS, 32'h5F, 32'h00000FFF);
    resp <= 1'b1;
    // mid-run resets: first with the clock enable held low, then unmasked faults
    for (int k = 0; k < 2; k++) begin
      reset_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      if (k == 0) begin
        ce <= 1'b0;
        repeat (100) @(posedge ref_clk_in);
        ce <= 1'b1;
      end
      bus(1'b0, REG_STATUS, 32'h0, 32'h1F1);
      fd <= fault(k == 0 ? F_CTRL : F_CLAMP);
      repeat (3) @(posedge ref_clk_in);
      fd <= idle;
      bus(1'b0, REG_STATUS, 32'h1, 32'h1);
    end
    close_out();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire

// ### include/apst_pkg.sv
package apst_pkg;
  // bus register offsets
  localparam logic [7:0] REG_SETTINGS = 8'h00;
  localparam logic [7:0] REG_FLAGS    = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  // settings field positions
  localparam int SET_GLOBAL_POS = 0;
  localparam int SET_TEST_POS   = 1;
  localparam int SET_MASK_POS   = 6;
  // flag field positions
  localparam int FLG_SEL_POS = 0;
  localparam int FLG_FIX_POS = 5;
  // status field positions
  localparam int STA_DIAG_POS = 0;
  localparam int STA_SEQ_POS  = 4;
  localparam int STA_PAR_POS  = 8;
  // counts
  localparam int N_SEL = 5;
  localparam int N_FIX = 7;
  // reset values
  localparam logic       RST_GLOBAL = 1'b1;
  localparam logic [4:0] RST_TESTS  = 5'h1F;
  localparam logic [6:0] RST_MASKS  = 7'h00;
  // selectable test indices
  localparam int T_FIELD = 0;
  localparam int T_INV   = 1;
  localparam int T_DIV   = 2;
  localparam int T_ROT   = 3;
  localparam int T_ADJ   = 4;
  // fixed check indices
  localparam int F_CTRL  = 0;
  localparam int F_COMPL = 1;
  localparam int F_PAR   = 2;
  localparam int F_CONV  = 3;
  localparam int F_ADD   = 4;
  localparam int F_ROTOV = 5;
  localparam int F_CLAMP = 6;
  // timing: failure reported within this many ns, 16 slots per frame
  localparam int CLK_MHZ        = 200;
  localparam int COMPLETION_NS  = 160000;
  localparam int COMPLETION_CYC = COMPLETION_NS * CLK_MHZ / 1000;
  localparam int SEQ_SLOTS      = 16;
  localparam int SLOT_CYC       = COMPLETION_CYC / SEQ_SLOTS;
  localparam int SLOT_FRAME_END = 15;
  // converter range threshold in percent
  localparam int CONV_LIMIT_PCT = 95;
  // data widths
  localparam int ANGLE_W = 16;
  localparam int TEMP_W  = 12;

  typedef struct packed {
    logic [6:0] fix_mask;
    logic [4:0] test_en;
    logic       global_en;
  } apst_settings_t;

  typedef struct packed {
    logic [TEMP_W-1:0]  temp_chip;
    logic [TEMP_W-1:0]  temp_amr;
    logic               temp_sensor_fail;
    logic [ANGLE_W-1:0] main_angle;
    logic [ANGLE_W-1:0] inv_angle;
    logic [ANGLE_W-1:0] clamp_lo;
    logic [ANGLE_W-1:0] clamp_hi;
    logic [ANGLE_W-1:0] div_result;
    logic [ANGLE_W-1:0] cordic_main;
    logic [ANGLE_W-1:0] cordic_inv;
    logic [ANGLE_W-1:0] zero_main;
    logic [ANGLE_W-1:0] zero_red;
    logic               redundant_fault;
  } apst_test_data_t;

  typedef struct packed {
    logic        ctrl_error;
    logic [15:0] sd_result;
    logic [7:0]  sd_gain;
    logic        adder_ovf;
    logic        rotation_ovf;
    logic        clamp_det;
    logic        range_det;
  } apst_fixed_data_t;
endpackage

// ### verilog/apst_selftest.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - selectable tests run only under global enable
// - each selectable test has its own enable
// - chip temperature versus amplitude temperature plausibility
// - temperature sensor fault forces diagnostic mode
// - main plus mirrored angle equals clamp sum
// - test division checked against known result
// - division feeds angle only in seventeen-point mode
// - main plus inverse rotation angle equals zero
// - zero-corrected angle matches redundant unit result
// - fixed checks always run, each maskable
// - flag main path processing errors
// - selected test failure flagged within 160 us
// - sequencer state parity protected, mismatch flags
// - converter result above 95 percent flags
// - shared pre-rotation adder overflow flags
// - rotation datapath overflow flags
// - clamp seen before range position flags
// - 4-bit up-counter slots trigger each test
// - ready clears start; missing ready forces diagnostic
module apst_selftest #(
  parameter int SLOT_CYCLES = apst_pkg::SLOT_CYC,
  parameter int TEMP_TOL    = 64,
  parameter int DIV_EXPECT  = 16'h1234,
  parameter int GAIN_FRAC   = 7
) (
  // clock, reset, enable
  input  wire logic                       ref_clk_in,
  input  wire logic                       reset_in,
  input  wire logic                       ce_in,
  // wishbone slave
  input  wire logic                       wb_cyc_in,
  input  wire logic                       wb_stb_in,
  input  wire logic                       wb_we_in,
  input  wire logic [7:0]                 wb_adr_in,
  input  wire logic [3:0]                 wb_sel_in,
  input  wire logic [31:0]                wb_dat_in,
  output logic      [31:0]                wb_dat_out,
  output logic                            wb_ack_out,
  // test engines
  output logic      [apst_pkg::N_SEL-1:0] test_start_out,
  input  wire logic [apst_pkg::N_SEL-1:0] test_ready_in,
  input  wire apst_pkg::apst_test_data_t  test_data_in,
  // fixed check sources
  input  wire apst_pkg::apst_fixed_data_t fixed_data_in,
  // calibration mode and results
  input  wire logic                       seventeen_point_calibration_in,
  output logic                            div_to_angle_out,
  output logic                            diag_request_out
);
  import apst_pkg::*;

  localparam logic [12:0] SLOT_LAST = 13'(SLOT_CYCLES - 1);

  // state
  apst_settings_t       settings_q;
  apst_settings_t       next_settings;
  logic [N_SEL-1:0]     sel_flag_q;
  logic [N_SEL-1:0]     next_sel_flag;
  logic [N_FIX-1:0]     fix_flag_q;
  logic [N_FIX-1:0]     next_fix_flag;
  logic [N_SEL-1:0]     start_q;
  logic [N_SEL-1:0]     next_start;
  logic [N_SEL-1:0]     frame_fail_q;
  logic [N_SEL-1:0]     next_frame_fail;
  logic [3:0]           seq_q;
  logic [3:0]           next_seq;
  logic                 par_q;
  logic                 next_par;
  logic [12:0]          slot_cnt_q;
  logic [12:0]          next_slot_cnt;
  logic                 diag_q;
  logic                 next_diag;
  logic                 ack_q;
  logic                 next_ack;
  logic [31:0]          rdata_q;
  logic [31:0]          next_rdata;
  logic                 div_sel_q;
  logic                 next_div_sel;

  // combinational check results
  logic [N_SEL-1:0]     test_bad;
  logic [N_FIX-1:0]     fix_raw;
  logic [TEMP_W-1:0]    temp_diff;
  logic [ANGLE_W:0]     angle_sum;
  logic [ANGLE_W:0]     clamp_sum;
  logic [ANGLE_W-1:0]   rot_sum;
  logic [15:0]          sd_mag;
  logic [23:0]          sd_prod;
  logic [31:0]          sd_scaled;
  logic                 slot_end;
  logic                 wb_req;
  logic                 wb_wr;
  logic [N_SEL-1:0]     sel_clr;
  logic [N_FIX-1:0]     fix_clr;
  logic                 hit_settings;
  logic                 hit_flags;
  logic                 hit_status;

  // data checks for selectable tests
  always_comb begin
    temp_diff = (test_data_in.temp_chip > test_data_in.temp_amr)
              ? test_data_in.temp_chip - test_data_in.temp_amr
              : test_data_in.temp_amr - test_data_in.temp_chip;
    angle_sum = {1'b0, test_data_in.main_angle} + {1'b0, test_data_in.inv_angle};
    clamp_sum = {1'b0, test_data_in.clamp_lo} + {1'b0, test_data_in.clamp_hi};
    rot_sum   = test_data_in.cordic_main + test_data_in.cordic_inv;
    test_bad[T_FIELD] = (32'(temp_diff) > 32'(TEMP_TOL)) || test_data_in.temp_sensor_fail;
    test_bad[T_INV]   = angle_sum != clamp_sum;
    test_bad[T_DIV]   = test_data_in.div_result != 16'(DIV_EXPECT);
    test_bad[T_ROT]   = rot_sum != '0;
    test_bad[T_ADJ]   = (test_data_in.zero_main != test_data_in.zero_red)
                      || test_data_in.redundant_fault;
  end

  // fixed checks, evaluated every cycle
  always_comb begin
    sd_mag    = fixed_data_in.sd_result[15] ? 16'(-fixed_data_in.sd_result) : fixed_data_in.sd_result;
    sd_prod   = 24'(sd_mag) * 24'(fixed_data_in.sd_gain);
    sd_scaled = 32'(sd_prod >> GAIN_FRAC);
    fix_raw[F_CTRL]  = fixed_data_in.ctrl_error;
    fix_raw[F_COMPL] = 1'b0;
    fix_raw[F_PAR]   = ^{seq_q, par_q};
    fix_raw[F_CONV]  = (sd_scaled * 32'd100) > (32'(CONV_LIMIT_PCT) * 32'h0000_8000);
    fix_raw[F_ADD]   = fixed_data_in.adder_ovf;
    fix_raw[F_ROTOV] = fixed_data_in.rotation_ovf;
    fix_raw[F_CLAMP] = fixed_data_in.clamp_det && !fixed_data_in.range_det;
  end

  // address decode, one hit per register; unmapped addresses hit nothing
  always_comb begin
    hit_settings = 1'b0;
    hit_flags    = 1'b0;
    hit_status   = 1'b0;
    if (wb_adr_in == REG_SETTINGS) begin
      hit_settings = 1'b1;
    end else if (wb_adr_in == REG_FLAGS) begin
      hit_flags = 1'b1;
    end else if (wb_adr_in == REG_STATUS) begin
      hit_status = 1'b1;
    end
  end

  // bus decode helpers
  always_comb begin
    wb_req  = wb_cyc_in && wb_stb_in && !ack_q;
    wb_wr   = wb_req && wb_we_in;
    sel_clr = '0;
    fix_clr = '0;
    if (wb_wr && hit_flags && wb_sel_in[0]) begin
      sel_clr = wb_dat_in[FLG_SEL_POS +: N_SEL];
      fix_clr[2:0] = wb_dat_in[FLG_FIX_POS +: 3];
    end
    if (wb_wr && hit_flags && wb_sel_in[1]) begin
      fix_clr[6:3] = wb_dat_in[FLG_FIX_POS + 3 +: 4];
    end
  end

  // sequencer, test handshakes and flags
  always_comb begin
    next_seq        = seq_q;
    next_par        = par_q;
    next_slot_cnt   = slot_cnt_q;
    next_start      = start_q;
    next_frame_fail = frame_fail_q;
    next_sel_flag   = sel_flag_q & ~sel_clr;
    next_fix_flag   = fix_flag_q & ~fix_clr;
    next_diag       = diag_q;
    slot_end        = slot_cnt_q == SLOT_LAST;
    // slot timer and 4-bit up-counter
    if (slot_end) begin
      next_slot_cnt = '0;
      next_seq      = seq_q + 4'h1;
      next_par      = ^(seq_q + 4'h1);
    end else begin
      next_slot_cnt = slot_cnt_q + 13'h0001;
    end
    // start trigger per slot, cleared by ready
    for (int i = 0; i < N_SEL; i++) begin
      if (start_q[i] && test_ready_in[i]) begin
        next_start[i] = 1'b0;
        if (test_bad[i]) begin
          next_frame_fail[i] = 1'b1;
        end
      end else if (start_q[i] && slot_end) begin
        next_start[i]      = 1'b0;
        next_frame_fail[i] = 1'b1;
      end
      if (slot_cnt_q == '0 && 32'(seq_q) == i && settings_q.global_en
          && settings_q.test_en[i]) begin
        next_start[i] = 1'b1;
      end
      if (!settings_q.global_en || !settings_q.test_en[i]) begin
        next_start[i]      = 1'b0;
        next_frame_fail[i] = 1'b0;
      end
    end
    // frame end: report failures of this frame
    if (slot_end && seq_q == 4'(SLOT_FRAME_END)) begin
      next_sel_flag = next_sel_flag | frame_fail_q;
      if (frame_fail_q != '0) begin
        next_fix_flag[F_COMPL] = 1'b1;
      end
      next_frame_fail = '0;
    end
    // fixed checks set their sticky flags, set wins over clear
    next_fix_flag = next_fix_flag | fix_raw;
    // diagnostic request latches until reset
    if ((fix_flag_q & ~settings_q.fix_mask) != '0 || sel_flag_q != '0) begin
      next_diag = 1'b1;
    end
  end

  // mode copy: the divider feeds the angle only in seventeen-point mode
  always_comb begin
    next_div_sel = seventeen_point_calibration_in;
  end

  // register bus: settings write and read mux
  always_comb begin
    next_settings = settings_q;
    next_ack      = wb_req;
    next_rdata    = rdata_q;
    if (wb_wr && hit_settings) begin
      if (wb_sel_in[0]) begin
        next_settings.global_en = wb_dat_in[SET_GLOBAL_POS];
        next_settings.test_en   = wb_dat_in[SET_TEST_POS +: N_SEL];
        next_settings.fix_mask[1:0] = wb_dat_in[SET_MASK_POS +: 2];
      end
      if (wb_sel_in[1]) begin
        next_settings.fix_mask[6:2] = wb_dat_in[SET_MASK_POS + 2 +: 5];
      end
    end
    if (wb_req && !wb_we_in) begin
      if (hit_settings) begin
        next_rdata = {19'h0, settings_q.fix_mask, settings_q.test_en, settings_q.global_en};
      end else if (hit_flags) begin
        next_rdata = {20'h0, fix_flag_q, sel_flag_q};
      end else if (hit_status) begin
        next_rdata = {23'h0, par_q, seq_q, 3'h0, diag_q};
      end else begin
        next_rdata = 32'h0000_0000;
      end
    end
  end

  // bus group registers: settings, ack and read data
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      settings_q <= '{fix_mask: RST_MASKS, test_en: RST_TESTS, global_en: RST_GLOBAL};
      ack_q      <= 1'b0;
      rdata_q    <= 32'h0000_0000;
    end else if (ce_in) begin
      settings_q <= next_settings;
      ack_q      <= next_ack;
      rdata_q    <= next_rdata;
    end
  end

  // sequencer, handshake and flag registers
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      sel_flag_q   <= '0;
      fix_flag_q   <= '0;
      start_q      <= '0;
      frame_fail_q <= '0;
      seq_q        <= 4'h0;
      par_q        <= 1'b0;
      slot_cnt_q   <= 13'h0000;
      diag_q       <= 1'b0;
    end else if (ce_in) begin
      sel_flag_q   <= next_sel_flag;
      fix_flag_q   <= next_fix_flag;
      start_q      <= next_start;
      frame_fail_q <= next_frame_fail;
      seq_q        <= next_seq;
      par_q        <= next_par;
      slot_cnt_q   <= next_slot_cnt;
      diag_q       <= next_diag;
    end
  end

  // mode copy register
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      div_sel_q <= 1'b0;
    end else if (ce_in) begin
      div_sel_q <= next_div_sel;
    end
  end

  // outputs
  assign wb_ack_out       = ack_q;
  assign wb_dat_out       = rdata_q;
  assign test_start_out   = start_q;
  assign div_to_angle_out = div_sel_q;
  assign diag_request_out = diag_q;

endmodule
`default_nettype wire
